/* File: cie_core_model.sv */
// partner: behavioural instruction sequencer with a small return stack
`timescale 1ns/1ps
module cie_core_model (
   input wire logic              pclk,  // cpu clock
   input wire logic              presetn, // async reset, low
   input wire cie_pkg::cie_seq_s seq,   // from block
   input wire logic [4:0]        rq,    // hold, sleep, ret, clr, set
   output cie_pkg::cie_core_s    core   // to block
);
   logic [15:0] pc_r;
   logic [15:0] stk_r [8];
   logic [2:0]  top_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_r  <= 16'h0100;
         top_r <= 3'h0;
      end else begin
         if (seq.jump) pc_r <= seq.vector_pc;
         else if (core.instr_done) pc_r <= pc_r + 16'h0001;
         if (seq.push) stk_r[top_r] <= seq.push_pc;
         top_r <= top_r + 3'(seq.push) - 3'(seq.pop);
      end
   end
   // hold stretches one instruction over many cycles
   assign core = '{instr_done: !seq.stall && !rq[4], set_gie: rq[0], clr_gie: rq[1],
      ret_handler: rq[2], sleeping: rq[3], pc: pc_r, pop_pc: stk_r[top_r - 3'h1]};
endmodule // cie_core_model

/* File: cie_pkg.sv */
// package: constants, types and rule summary for the cpu interrupt entry logic
// What this block does
// - each source and reset own a vector; taken only if own and global enable set
// - lowest vector address wins; reset first, external request zero next
// - vector select bit in core control register moves vectors to boot start
// - boot reset fuse moves the reset vector to boot section start
// - programmed boot lock bits may suppress interrupts depending on program counter
// - accepting an interrupt clears global enable until software sets it
// - return from handler sets global enable
// - vectoring clears the flag of a flag-latched source
// - writing one to a flag clears it, zero leaves it
// - flag set while disabled is held until enabled or cleared
// - flags held while global enable is off are served in priority order
// - level sources request only while their condition is present
// - after return one main instruction runs before the next interrupt
// - status register is never saved or restored by entry or return
// - clear-global-enable acts at once, also on a same-cycle request
// - after set-global-enable the next instruction runs before any interrupt
// - entry takes at least five cycles while the program counter is pushed
// - multi-cycle instruction completes before an interrupt is served
// - wake from sleep adds five cycles to the entry response
// - return takes five cycles: three bytes popped, stack pointer plus three, enable set
// - saved program counter is sixteen bits, a word address
// - entry push lowers the stack pointer by three; stack grows downward
package cie_pkg;
   localparam int          NUM_SRC          = 8;
   localparam int          PC_W             = 16;
   localparam int          SP_W             = 16;
   localparam logic [15:0] BOOT_START_DEF   = 16'h3800;
   localparam logic [15:0] RESET_VEC        = 16'h0000;
   localparam logic [15:0] VEC_STEP         = 16'h0002;
   localparam logic [15:0] SP_RESET         = 16'h0aff;
   localparam logic [15:0] STACK_BYTES      = 16'h0003;
   localparam int          ENTRY_CYC        = 5;
   localparam int          RETURN_CYC       = 5;
   localparam int          WAKE_EXTRA_CYC   = 5;
   localparam logic [3:0]  ENTRY_CNT        = 4'(ENTRY_CYC);
   localparam logic [3:0]  RETURN_CNT       = 4'(RETURN_CYC);
   localparam logic [3:0]  WAKE_CNT         = 4'(ENTRY_CYC + WAKE_EXTRA_CYC);
   // apb map
   localparam logic [7:0]  A_FLAG           = 8'h00;
   localparam logic [7:0]  A_ENABLE         = 8'h04;
   localparam logic [7:0]  A_LEVEL          = 8'h08;
   localparam logic [7:0]  A_CTRL           = 8'h0c;
   localparam logic [7:0]  A_STATUS         = 8'h10;
   localparam logic [7:0]  A_SP             = 8'h14;
   localparam logic [7:0]  A_BOOT           = 8'h18;
   localparam logic [7:0]  A_LOCK           = 8'h1c;
   // ctrl register bits
   localparam int          C_VSEL           = 0;
   localparam int          C_GIE            = 1;

   typedef enum logic [2:0] {
      CIE_RUN    = 3'b000,
      CIE_ENTRY  = 3'b001,
      CIE_RETURN = 3'b010,
      CIE_AFTER  = 3'b011
   } cie_state_e;

   // sequencer handshake from the core
   typedef struct packed {
      logic             instr_done;   // boundary of any instruction
      logic             set_gie;      // set-global-enable retiring
      logic             clr_gie;      // clear-global-enable decoding
      logic             ret_handler;  // return_from_handler_instr issued
      logic             sleeping;     // core asleep
      logic [15:0]      pc;           // next main program counter
      logic [15:0]      pop_pc;       // word popped from stack
   } cie_core_s;

   typedef struct packed {
      logic             stall;        // sequencer held
      logic             push;         // pc push strobe
      logic             pop;          // pc pop strobe
      logic [15:0]      push_pc;      // pc pushed
      logic             jump;         // load vector_pc
      logic [15:0]      vector_pc;    // target word address
   } cie_seq_s;
endpackage

/* File: cie_top.sv */
// module: interrupt entry, priority, vector relocation and return sequencing
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module cie_top #(
   parameter int NSRC = cie_pkg::NUM_SRC
) (
   input  wire logic                pclk,       // cpu clock
   input  wire logic                presetn,    // async reset, low
   input  wire logic                ce,         // clock enable
   input  wire logic [7:0]          paddr,      // apb address
   input  wire logic                psel,       // apb select
   input  wire logic                penable,    // apb enable
   input  wire logic                pwrite,     // apb direction
   input  wire logic [31:0]         pwdata,     // apb write data
   output logic      [31:0]         prdata,     // apb read data
   output logic                     pready,     // apb ready
   output logic                     pslverr,    // apb error
   input  wire logic [NSRC-1:0]     src_event,  // async flag conditions
   input  wire logic [NSRC-1:0]     src_level,  // async level conditions
   input  wire logic                boot_reset_fuse, // strap
   input  wire logic                app_boot_lock_bit,     // strap
   input  wire logic                boot_section_lock_bit, // strap
   input  wire cie_pkg::cie_core_s  core_i,     // from sequencer
   output cie_pkg::cie_seq_s        seq_o,      // to sequencer
   output logic      [15:0]         sp_o,       // stack pointer
   output logic                     gie_o       // global enable
);
   logic [NSRC-1:0]   ev_s1_r, ev_s2_r, ev_s3_r, lv_s1_r, lv_s2_r;
   logic [NSRC-1:0]   flag_r, en_r, is_level_r, req;
   logic              gie_r, vsel_r, fuse_r, lk_a_r, lk_b_r;
   logic [15:0]       boot_start_r, sp_r, lock_lo_r, lock_hi_r;
   logic [3:0]        cnt_r;
   logic [1:0]        bytec_r;
   logic              wake_r, block_r;
   logic [$clog2(NSRC)-1:0] win_r, win;
   logic              any;
   cie_pkg::cie_state_e st_r;
   logic              wr, rd, clr_flag;
   logic [15:0]       vec_base;

   assign wr = psel & penable & pwrite & ce;
   assign rd = psel & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign gie_o = gie_r;
   assign sp_o  = sp_r;

   // two-stage sync on external conditions; third stage only feeds edge detect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_s1_r <= '0; ev_s2_r <= '0; ev_s3_r <= '0; lv_s1_r <= '0; lv_s2_r <= '0;
      end else if (ce) begin
         ev_s1_r <= src_event; ev_s2_r <= ev_s1_r; ev_s3_r <= ev_s2_r;
         lv_s1_r <= src_level; lv_s2_r <= lv_s1_r;
      end
   end

   // straps caught after release, not under reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_r <= 1'b0; lk_a_r <= 1'b0; lk_b_r <= 1'b0;
      end else if (ce) begin
         fuse_r <= boot_reset_fuse;
         lk_a_r <= app_boot_lock_bit;
         lk_b_r <= boot_section_lock_bit;
      end
   end

   // request vector: flag sources latch, level sources follow the live condition
   always_comb begin
      for (int i = 0; i < NSRC; i++)
         req[i] = en_r[i] & (is_level_r[i] ? lv_s2_r[i] : flag_r[i]);
   end

   // lowest index is lowest vector address: fixed priority
   always_comb begin
      win = '0;
      any = 1'b0;
      for (int i = NSRC-1; i >= 0; i--)
         if (req[i]) begin
            win = ($clog2(NSRC))'(i);
            any = 1'b1;
         end
   end

   // lock window: interrupts blocked while pc lies in [lo,hi] with a lock bit set
   assign block_r = (lk_a_r | lk_b_r) & (core_i.pc >= lock_lo_r) & (core_i.pc <= lock_hi_r);

   wire take = (st_r == cie_pkg::CIE_RUN) & any & gie_r & ~core_i.clr_gie & ~block_r
               & core_i.instr_done & ~core_i.set_gie & ~core_i.ret_handler;
   assign clr_flag = take & ~is_level_r[win];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= '0;
      end else if (ce) begin
         for (int i = 0; i < NSRC; i++) begin
            if (ev_s2_r[i] & ~ev_s3_r[i])
               flag_r[i] <= 1'b1; // set wins over clear
            else if ((wr && paddr == cie_pkg::A_FLAG && pwdata[i]) ||
                     (clr_flag && win == ($clog2(NSRC))'(i)))
               flag_r[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= '0; is_level_r <= '0; vsel_r <= 1'b0;
         boot_start_r <= cie_pkg::BOOT_START_DEF; lock_lo_r <= '0; lock_hi_r <= '0;
      end else if (wr) begin
         case (paddr)
            cie_pkg::A_ENABLE: en_r <= pwdata[NSRC-1:0];
            cie_pkg::A_LEVEL:  is_level_r <= pwdata[NSRC-1:0];
            cie_pkg::A_CTRL:   vsel_r <= pwdata[cie_pkg::C_VSEL];
            cie_pkg::A_BOOT:   boot_start_r <= pwdata[15:0];
            cie_pkg::A_LOCK: begin
               lock_lo_r <= pwdata[15:0];
               lock_hi_r <= pwdata[31:16];
            end
            default: ;
         endcase
      end
   end

   // global enable: cleared on entry and by clr, set on return or sei
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gie_r <= 1'b0;
      else if (ce) begin
         if (take | core_i.clr_gie) gie_r <= 1'b0;
         else if (st_r == cie_pkg::CIE_RETURN && cnt_r == 4'h1) gie_r <= 1'b1;
         else if (core_i.set_gie) gie_r <= 1'b1;
         else if (wr && paddr == cie_pkg::A_CTRL) gie_r <= pwdata[cie_pkg::C_GIE];
      end
   end

   assign vec_base = vsel_r ? boot_start_r : cie_pkg::RESET_VEC;

   // sequencer: entry push, return pop, one main instruction after return
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= cie_pkg::CIE_RUN; cnt_r <= '0; win_r <= '0; wake_r <= 1'b0;
         sp_r <= cie_pkg::SP_RESET; bytec_r <= '0; seq_o <= '0;
      end else if (ce) begin
         seq_o.push <= 1'b0;
         seq_o.pop  <= 1'b0;
         seq_o.jump <= 1'b0;
         case (st_r)
            cie_pkg::CIE_RUN: begin
               seq_o.stall <= 1'b0;
               if (take) begin
                  st_r <= cie_pkg::CIE_ENTRY;
                  win_r <= win;
                  cnt_r <= core_i.sleeping ? cie_pkg::WAKE_CNT : cie_pkg::ENTRY_CNT;
                  seq_o.stall <= 1'b1;
                  seq_o.push <= 1'b1;
                  seq_o.push_pc <= core_i.pc;
                  sp_r <= sp_r - cie_pkg::STACK_BYTES;
               end else if (core_i.ret_handler) begin
                  st_r <= cie_pkg::CIE_RETURN;
                  cnt_r <= cie_pkg::RETURN_CNT;
                  seq_o.stall <= 1'b1;
               end
            end
            cie_pkg::CIE_ENTRY: begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1) begin
                  st_r <= cie_pkg::CIE_RUN;
                  seq_o.stall <= 1'b0;
                  seq_o.jump <= 1'b1;
                  seq_o.vector_pc <= vec_base + VEC_OFF(win_r);
               end
            end
            cie_pkg::CIE_RETURN: begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1) begin
                  st_r <= cie_pkg::CIE_AFTER;
                  seq_o.stall <= 1'b0;
                  seq_o.pop <= 1'b1;
                  seq_o.jump <= 1'b1;
                  seq_o.vector_pc <= core_i.pop_pc;
                  sp_r <= sp_r + cie_pkg::STACK_BYTES;
               end
            end
            cie_pkg::CIE_AFTER: begin
               if (core_i.instr_done) st_r <= cie_pkg::CIE_RUN;
            end
            default: st_r <= cie_pkg::CIE_RUN;
         endcase
      end
   end

   // vector n of source i sits at (i+1)*step; reset vector is slot 0
   function automatic logic [15:0] VEC_OFF(input logic [$clog2(NSRC)-1:0] i);
      VEC_OFF = 16'(({12'h000, 4'(i)} + 16'h0001) * cie_pkg::VEC_STEP);
   endfunction

   // reset vector offered as read-only status
   wire [15:0] reset_vec = fuse_r ? boot_start_r : cie_pkg::RESET_VEC;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= '0;
      else if (rd && ce) begin
         case (paddr)
            cie_pkg::A_FLAG:   prdata <= 32'(flag_r);
            cie_pkg::A_ENABLE: prdata <= 32'(en_r);
            cie_pkg::A_LEVEL:  prdata <= 32'(is_level_r);
            cie_pkg::A_CTRL:   prdata <= {30'h0, gie_r, vsel_r};
            cie_pkg::A_STATUS: prdata <= {reset_vec, 5'h00, st_r, 4'(win_r), any, 3'h0};
            cie_pkg::A_SP:     prdata <= {16'h0000, sp_r};
            cie_pkg::A_BOOT:   prdata <= {16'h0000, boot_start_r};
            cie_pkg::A_LOCK:   prdata <= {lock_hi_r, lock_lo_r};
            default:           prdata <= '0;
         endcase
      end
   end
endmodule // cie_top

/* File: cie_top_sva.sv */
// checker: timing and ordering properties on the interrupt entry block ports
`timescale 1ns/1ps
module cie_top_chk (
   input wire logic               pclk,    // cpu clock
   input wire logic               presetn, // async reset, low
   input wire cie_pkg::cie_core_s core_i,  // from sequencer
   input wire cie_pkg::cie_seq_s  seq_o,   // to sequencer
   input wire logic [15:0]        sp_o,    // stack pointer
   input wire logic               gie_o    // global enable
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   entry_gie_a: assert property (seq_o.push |-> ##[0:1] !gie_o)
      else $error("global enable left set on entry");
   entry_len_a: assert property (seq_o.push && !core_i.sleeping |-> ##5 seq_o.jump)
      else $error("vector jump not within entry time");
   clr_block_a: assert property (core_i.clr_gie |=> !seq_o.push)
      else $error("interrupt taken with clear of enable");
   set_next_a: assert property (core_i.set_gie |=> !seq_o.push)
      else $error("interrupt taken right after set of enable");
   ret_len_a: assert property (core_i.ret_handler |-> ##[4:6] (seq_o.pop && seq_o.jump))
      else $error("return not finished in time");
   ret_gie_a: assert property (seq_o.pop |-> ##[0:1] gie_o)
      else $error("global enable not set on return");
   ret_main_a: assert property (seq_o.pop |=> !seq_o.push
      ##1 (!seq_o.push || $past(core_i.instr_done, 2)))
      else $error("no main instruction after return");
   sp_step_a: assert property ($changed(sp_o) |-> sp_o == $past(sp_o) + 16'h0003
      || sp_o == $past(sp_o) - 16'h0003)
      else $error("stack pointer moved by other than three");
   pop_pc_a: assert property (seq_o.pop |-> seq_o.vector_pc == $past(core_i.pop_pc))
      else $error("return address differs from popped word");
   push_pc_a: assert property (seq_o.push |-> seq_o.push_pc == $past(core_i.pc))
      else $error("pushed address differs from main pc");
   entry_c: cover property (seq_o.push ##[1:12] seq_o.jump);
   wake_c: cover property (core_i.sleeping && seq_o.jump);
   ret_c: cover property (seq_o.pop);
endmodule // cie_top_chk
bind cie_top cie_top_chk chk_u (.pclk(pclk), .presetn(presetn), .core_i(core_i),
   .seq_o(seq_o), .sp_o(sp_o), .gie_o(gie_o));

/* File: tb_cpu_interrupt_entry_logic.sv */
// testbench: apb and sequencer driven checks of interrupt entry and return
`timescale 1ns/1ps
module tb_cpu_interrupt_entry_logic;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, gie, fuse = 0;
   logic [7:0]  paddr = 8'h00, ev = 8'h00, lv = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] sp, ret_pc;
   logic [4:0]  rq = 5'h00;
   logic        lk = 1'b0;
   cie_pkg::cie_core_s core;
   cie_pkg::cie_seq_s  seq;
   int fails = 0, cmp_count = 0, lat, lat1, pushes = 0;
   always #10 pclk = ~pclk;
   cie_top dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_event(ev), .src_level(lv), .boot_reset_fuse(fuse),
      .app_boot_lock_bit(lk), .boot_section_lock_bit(1'b0), .core_i(core), .seq_o(seq),
      .sp_o(sp), .gie_o(gie));
   cie_core_model core_u (.pclk(pclk), .presetn(presetn), .seq(seq), .rq(rq), .core(core));
   always @(posedge pclk) if (seq.push === 1'b1) pushes <= pushes + 1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      chk(32'(pslverr), 32'h0);
      psel <= 0; penable <= 0;
   endtask
   // k: 0 push, 1 jump, 2 pop; lat counts the cycles waited
   task automatic wait_ev(input int k);
      lat = 0;
      do begin @(posedge pclk); #1; lat++; end
      while (!(k == 0 ? seq.push === 1'b1 : k == 1 ? seq.jump === 1'b1 : seq.pop === 1'b1)
         && lat < 300);
      if (lat >= 300) chk(32'(k), 32'hffff);
   endtask
   task automatic pulse(input int k);
      @(posedge pclk); rq[k] <= 1;
      @(posedge pclk); rq[k] <= 0;
   endtask
   task automatic event_on(input logic [7:0] m);
      @(posedge pclk); ev <= m;
      repeat (2) @(posedge pclk); ev <= 8'h00;
      repeat (4) @(posedge pclk);
   endtask
   task automatic enter(input logic [15:0] vec, input logic [15:0] sp_exp);
      wait_ev(0); ret_pc = seq.push_pc; chk(32'(gie), 0);
      wait_ev(1); chk(32'(seq.vector_pc), 32'(vec)); chk(32'(sp), 32'(sp_exp));
   endtask
   task automatic leave();
      pulse(2); wait_ev(2); chk(32'(seq.vector_pc), 32'(ret_pc));
      @(posedge pclk); #1; chk(32'(sp), 32'h0aff); chk(32'(gie), 1);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #200000; fails++; test_done();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      #1; chk(32'(sp), 32'h0aff); chk(32'(gie), 0);
      apb(0, 8'h20, 0); chk(rd, 0);
      // pending while disabled, then served by priority with flag cleared
      apb(1, cie_pkg::A_ENABLE, 32'h06); event_on(8'h07);
      apb(0, cie_pkg::A_FLAG, 0); chk(rd, 32'h07);
      apb(1, cie_pkg::A_CTRL, 32'h02);
      enter(16'h0004, 16'h0afc); lat1 = lat;
      apb(0, cie_pkg::A_FLAG, 0); chk(rd, 32'h05);
      leave(); enter(16'h0006, 16'h0afc); leave();
      apb(1, cie_pkg::A_FLAG, 0); apb(0, cie_pkg::A_FLAG, 0); chk(rd, 32'h01);
      apb(1, cie_pkg::A_FLAG, 1); apb(0, cie_pkg::A_FLAG, 0); chk(rd, 32'h00);
      $display("test pending and priority done");
      // relocated vectors, asleep, held by a long instruction
      apb(1, cie_pkg::A_CTRL, 32'h03); apb(1, cie_pkg::A_ENABLE, 32'h08);
      rq[4] <= 1; rq[3] <= 1; event_on(8'h08); lat = pushes;
      repeat (6) @(posedge pclk); chk(pushes, lat);
      rq[4] <= 0;
      enter(16'h3808, 16'h0afc); chk(lat - lat1, 5);
      rq[3] <= 0; leave();
      $display("test relocation and wake done");
      // clear of enable blocks, set lets one instruction run first
      apb(1, cie_pkg::A_CTRL, 32'h02); apb(1, cie_pkg::A_ENABLE, 32'h10);
      pulse(1); event_on(8'h10); lat = pushes;
      repeat (6) @(posedge pclk); chk(pushes, lat); chk(32'(gie), 0);
      pulse(0); enter(16'h000a, 16'h0afc); leave();
      $display("test enable instructions done");
      // level type asks only while present
      apb(1, cie_pkg::A_CTRL, 0); apb(1, cie_pkg::A_LEVEL, 32'h20);
      apb(1, cie_pkg::A_ENABLE, 32'h20); event_on(8'h00);
      lv <= 8'h20; repeat (3) @(posedge pclk); lv <= 8'h00;
      apb(1, cie_pkg::A_CTRL, 32'h02); lat = pushes;
      repeat (8) @(posedge pclk); chk(pushes, lat);
      lv <= 8'h20; enter(16'h000c, 16'h0afc); lv <= 8'h00; leave();
      // lock window over the whole program space holds a pending request back
      apb(1, cie_pkg::A_LOCK, 32'hffff0000); lk <= 1'b1;
      apb(1, cie_pkg::A_ENABLE, 32'h40); event_on(8'h40);
      apb(1, cie_pkg::A_CTRL, 32'h02); lat = pushes;
      repeat (6) @(posedge pclk); chk(pushes, lat);
      lk <= 1'b0; enter(16'h000e, 16'h0afc); leave();
      apb(0, cie_pkg::A_STATUS, 0); chk(32'(rd[31:16]), 0);
      fuse <= 1; apb(0, cie_pkg::A_STATUS, 0); chk(32'(rd[31:16]), 32'h3800);
      $display("test level and reset vector done");
      test_done();
   end
endmodule // tb_cpu_interrupt_entry_logic
